// *** logic/lbc_pkg.sv ***
// Constants shared by the local bus cycle controller and its testbench.
// Assumes a single 20 MHz processor clock and an 8-bit multiplexed bus.
package lbc_pkg;

    // Widths of the address, data and wait-state fields.
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int WAIT_W = 4;
    localparam int HIGH_W = 12;

    // Cycle type codes driven on the three active-low status lines.
    localparam logic [2:0] ST_INTA  = 3'h0;
    localparam logic [2:0] ST_IORD  = 3'h1;
    localparam logic [2:0] ST_IOWR  = 3'h2;
    localparam logic [2:0] ST_HALT  = 3'h3;
    localparam logic [2:0] ST_FETCH = 3'h4;
    localparam logic [2:0] ST_MEMRD = 3'h5;
    localparam logic [2:0] ST_MEMWR = 3'h6;
    localparam logic [2:0] ST_NONE  = 3'h7;

    // Cycles that internal reset is held after the release has synchronised.
    localparam logic [2:0] RST_STRETCH = 3'h4;

    // Bus cycle sequencer states.
    typedef enum logic [2:0] {
        S_IDLE, S_T1, S_T2, S_T3, S_T4, S_HOLD
    } lbc_state_t;

endpackage : lbc_pkg

// *** logic/lbc_sync.sv ***
// Two-flop synchroniser for pin inputs, with a constant reset value.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/10ps
module lbc_sync #(
    parameter int         W  = 1,
    parameter logic [W-1:0] RV = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second, so metastability settles there.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RV;
            q      <= RV;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : lbc_sync

// *** logic/lbc_bus_ctrl.sv ***
// Local bus cycle controller: status code, strobes, lock, refresh, chip
// selects, hold hand-over, reset output and test-mode float.
// Assumes the core presents one request at a time and holds it until done.
// Overview of operation
// - Status lines carry 000 inta, 001 I/O read, 010 I/O write, 011 halt.
// - Status 100 is fetch, 101 memory read, 110 memory write, 111 idle.
// - A cycle ends only once ready is seen high, unless a select times it.
// - A cycle timed by a chip select ignores the ready input.
// - The read strobe goes low in read cycles and the target drives data.
// - The write strobe goes low while write data sit on the bus.
// - While lock is low no hold request is granted.
// - During reset the lock pin is only weakly pulled high.
// - Reset aborts any cycle and puts every pin at a defined level.
// - The reset output stays high for as long as reset is applied.
// - The refresh indicator is low through a refresh cycle only.
// - Upper and lower selects go low when a memory address is in range.
// - Test mode sampled low in reset floats every output pin; here only ad_oe, ctl_oe and lock_n_oe drop, hlda and resout stay driven.
// - The test-mode pin is weakly pulled high while reset is applied.
// - Hold is granted only at an instruction boundary outside a lock.
`timescale 1ns/10ps
module lbc_bus_ctrl
    import lbc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    input  wire logic [2:0]        req_type,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic              req_lock,
    input  wire logic              req_rfsh,
    input  wire logic              at_boundary,
    output logic                   req_done,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic [ADDR_W-1:0] ucs_base,
    input  wire logic [ADDR_W-1:0] ucs_limit,
    input  wire logic              ucs_en,
    input  wire logic              ucs_timed,
    input  wire logic [ADDR_W-1:0] lcs_base,
    input  wire logic [ADDR_W-1:0] lcs_limit,
    input  wire logic              lcs_en,
    input  wire logic              lcs_timed,
    input  wire logic [WAIT_W-1:0] cs_waits,
    input  wire logic              ready,
    input  wire logic              hold,
    input  wire logic              once_n,
    input  wire logic [DATA_W-1:0] ad_in,
    output logic      [DATA_W-1:0] ad_out,
    output logic                   ad_oe,
    output logic      [HIGH_W-1:0] addr_hi,
    output logic                   ale,
    output logic                   cycle_type_bit0_l,
    output logic                   cycle_type_bit1_l,
    output logic                   cycle_type_bit2_l,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic                   ctl_oe,
    output logic                   lock_n,
    output logic                   lock_n_oe,
    output logic                   lock_pullup,
    output logic                   once_pullup,
    output logic                   rfsh_n,
    output logic                   ucs_n,
    output logic                   lcs_n,
    output logic                   hlda,
    output logic                   resout
);
    // Cycle classes decoded in more than one place.
    function automatic logic is_read(input logic [2:0] t);
        return t == ST_INTA || t == ST_IORD || t == ST_FETCH || t == ST_MEMRD;
    endfunction : is_read

    function automatic logic is_write(input logic [2:0] t);
        return t == ST_IOWR || t == ST_MEMWR;
    endfunction : is_write

    function automatic logic in_range(input logic [2:0]        t,
                                      input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        return (t == ST_FETCH || t == ST_MEMRD || t == ST_MEMWR)
               && a >= lo && a <= hi;
    endfunction : in_range

    lbc_state_t        state_q;
    logic [1:0]        rst_pipe_q;
    logic [2:0]        rst_cnt_q;
    logic              float_q;
    logic              ready_s;
    logic              hold_s;
    logic              once_s;
    logic [DATA_W-1:0] ad_s;
    logic [2:0]        type_q;
    logic [DATA_W-1:0] wdata_q;
    logic              lock_req_q;
    logic              rfsh_q;
    logic              cs_gov_q;
    logic [WAIT_W-1:0] wait_q;
    logic [2:0]        status_q;
    logic              int_rst;
    logic              start;
    logic              grant;
    logic              term;
    logic              pins_on;

    // pin synchronisers
    // Test mode and ready reset to their idle high levels, hold to low.
    lbc_sync #(.W(3 + DATA_W), .RV({3'h5, {DATA_W{1'b0}}})) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({once_n, hold, ready, ad_in}),
        .q     ({once_s, hold_s, ready_s, ad_s})
    );

    // reset release sync
    // Assertion is asynchronous; release waits two flops plus a stretch so
    // the synchronised test-mode pin is settled before it is sampled.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
            rst_cnt_q  <= RST_STRETCH;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
            if (rst_pipe_q[1] && rst_cnt_q != 3'h0) begin
                rst_cnt_q <= rst_cnt_q - 3'h1;
            end
        end
    end

    assign int_rst = rst_cnt_q != 3'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resout      <= 1'b1;
            lock_pullup <= 1'b1;
            once_pullup <= 1'b1;
        end else begin
            resout      <= int_rst;
            lock_pullup <= int_rst;
            once_pullup <= int_rst;
        end
    end

    // test mode capture
    // Sampled every stretch cycle; the last sample before release sticks.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            float_q <= 1'b0;
        end else if (int_rst) begin
            float_q <= !once_s;
        end
    end

    assign grant = hold_s && at_boundary && lock_n && !int_rst;
    // A request still up in the done cycle belongs to the finished cycle,
    // so the core may hold it until the edge at which it sees req_done.
    assign start = req_valid && !grant && !int_rst && !req_done;
    assign term  = cs_gov_q ? (wait_q == '0) : ready_s;

    // sequencer abort
    // Every cycle takes at least four clocks: T1 address, T2 strobe, T3 wait
    // for termination, T4 recovery with status already idle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (grant) begin
                        state_q <= S_HOLD;
                    end else if (start) begin
                        state_q <= S_T1;
                    end
                end
                S_T1: state_q <= S_T2;
                S_T2: state_q <= S_T3;
                S_T3: begin
                    if (term) begin
                        state_q <= S_T4;
                    end
                end
                S_T4: state_q <= S_IDLE;
                S_HOLD: begin
                    if (!hold_s) begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Request capture and chip-select wait counter.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            type_q     <= ST_NONE;
            wdata_q    <= '0;
            lock_req_q <= 1'b0;
            rfsh_q     <= 1'b0;
            cs_gov_q   <= 1'b0;
            wait_q     <= '0;
        end else if (state_q == S_IDLE && start) begin
            type_q     <= req_type;
            wdata_q    <= req_wdata;
            lock_req_q <= req_lock;
            rfsh_q     <= req_rfsh;
            cs_gov_q   <= (ucs_en && ucs_timed &&
                           in_range(req_type, req_addr, ucs_base, ucs_limit))
                       || (lcs_en && lcs_timed &&
                           in_range(req_type, req_addr, lcs_base, lcs_limit));
            wait_q     <= cs_waits;
        end else if (state_q == S_T3 && wait_q != '0) begin
            wait_q <= wait_q - WAIT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= ST_NONE;
        end else if (state_q == S_IDLE && start) begin
            status_q <= req_type;
        end else if (state_q == S_T3 && term) begin
            status_q <= ST_NONE;
        end
    end

    assign cycle_type_bit0_l = status_q[0];
    assign cycle_type_bit1_l = status_q[1];
    assign cycle_type_bit2_l = status_q[2];

    // Address phase: latch enable and address lines.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ale     <= 1'b0;
            addr_hi <= '0;
        end else begin
            ale <= state_q == S_IDLE && start;
            if (state_q == S_IDLE && start) begin
                addr_hi <= req_addr[ADDR_W-1:DATA_W];
            end
        end
    end

    // write strobe
    // Read data are taken in T4 from the synchronised bus, which by then
    // reflects what the target drove since T2; the strobe releases at that same edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_n     <= 1'b1;
            wr_n     <= 1'b1;
            ad_out   <= '0;
            ad_oe    <= 1'b0;
            rd_data  <= '0;
            req_done <= 1'b0;
        end else begin
            req_done <= state_q == S_T4;
            if (state_q == S_IDLE && start) begin
                ad_out <= req_addr[DATA_W-1:0];
                ad_oe  <= !float_q;
            end else if (state_q == S_T1) begin
                rd_n   <= !is_read(type_q);
                wr_n   <= !is_write(type_q);
                ad_out <= wdata_q;
                ad_oe  <= !float_q && is_write(type_q);
            end else if (state_q == S_T3 && term) begin
                wr_n <= 1'b1;
            end else if (state_q == S_T4) begin
                rd_n    <= 1'b1;
                ad_oe   <= 1'b0;
                rd_data <= ad_s;
            end
        end
    end

    // lock blocks hold
    // Lock falls with a locked cycle and lifts after the first unlocked one,
    // so a locked sequence keeps the bus until its last cycle finishes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_n <= 1'b1;
        end else if (state_q == S_IDLE && start && req_lock) begin
            lock_n <= 1'b0;
        end else if (state_q == S_T4 && !lock_req_q) begin
            lock_n <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rfsh_n <= 1'b1;
            ucs_n  <= 1'b1;
            lcs_n  <= 1'b1;
        end else if (state_q == S_IDLE && start) begin
            rfsh_n <= !req_rfsh;
            ucs_n  <= !(ucs_en &&
                        in_range(req_type, req_addr, ucs_base, ucs_limit));
            lcs_n  <= !(lcs_en &&
                        in_range(req_type, req_addr, lcs_base, lcs_limit));
        end else if (state_q == S_T4) begin
            rfsh_n <= 1'b1;
            ucs_n  <= 1'b1;
            lcs_n  <= 1'b1;
        end
    end

    assign pins_on = !float_q && !int_rst;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hlda      <= 1'b0;
            ctl_oe    <= 1'b0;
            lock_n_oe <= 1'b0;
        end else begin
            hlda      <= (state_q == S_IDLE && grant)
                      || (state_q == S_HOLD && hold_s);
            ctl_oe    <= pins_on && !(state_q == S_IDLE && grant)
                      && !(state_q == S_HOLD && hold_s);
            lock_n_oe <= pins_on;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_status_type: assert property (
        state_q == S_IDLE && start |=> status_q == $past(req_type))
        else $error("status code does not match request");
    a_status_idle: assert property (
        state_q == S_T4 |-> status_q == ST_NONE)
        else $error("status not idle in recovery state");
    a_ready_wait: assert property (
        state_q == S_T3 && !cs_gov_q && !ready_s |=> state_q == S_T3)
        else $error("cycle ended without ready");
    a_cs_ignore: assert property (
        state_q == S_T3 && cs_gov_q && wait_q == '0 |=> state_q == S_T4)
        else $error("timed select cycle did not end");
    a_rd_strobe: assert property (
        $fell(rd_n) |-> is_read(type_q) && !ad_oe ##2 !rd_n)
        else $error("read strobe wrong");
    a_wr_strobe: assert property (
        $fell(wr_n) |-> ad_out == wdata_q && ad_oe == !float_q)
        else $error("write strobe without data");
    a_lock_hold: assert property (
        !lock_n |=> !$rose(hlda))
        else $error("hold granted under lock");
    a_reset_out: assert property (
        int_rst |=> resout)
        else $error("reset output low during reset");
    a_rfsh_low: assert property (
        state_q == S_T2 |-> rfsh_n == !rfsh_q)
        else $error("refresh indicator wrong");
    a_float_pins: assert property (
        float_q && !int_rst |=> !ad_oe && !ctl_oe && !lock_n_oe)
        else $error("pins driven in test mode");
    a_hold_bnd: assert property (
        $rose(hlda) |-> $past(at_boundary) && $past(lock_n))
        else $error("hold granted off boundary");

    c_read_done: cover property (state_q == S_T4 && is_read(type_q));
    c_write_done: cover property (state_q == S_T4 && is_write(type_q));
    c_hold_grant: cover property ($rose(hlda));
    c_cs_timed: cover property (state_q == S_T3 && cs_gov_q && !ready_s
                                ##1 state_q == S_T4);
endmodule : lbc_bus_ctrl

// *** tb/lbc_mem_model.sv ***
// Behavioural memory and I/O target on the multiplexed local bus.
// Assumes the controller puts a low address byte out with ale.
`timescale 1ns/10ps
module lbc_mem_model (
    input  wire logic       clk,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [3:0] wait_cfg,
    output logic      [7:0] ad_in,
    output logic            ready
);
    logic [7:0] mem_q [16];
    logic [3:0] adr_q;
    logic [3:0] cnt_q = 4'h0;
    logic [7:0] last_q = 8'h00;

    // target drives data.
    // A released bus shows the inverse of its last level, so a stale
    // value can never pass for fresh read data.
    assign ad_in = ad_oe ? ad_out : (!rd_n ? mem_q[adr_q] : ~last_q);

    // ready ends cycle.
    // Setting 0 is always ready, f is never ready, else wait clocks.
    assign ready = (wait_cfg == 4'h0) || (wait_cfg != 4'hf &&
                   !(rd_n && wr_n) && cnt_q >= wait_cfg);

    // lock pin untouched; the lock pin is never driven from here.
    always_ff @(posedge clk) begin
        last_q <= ad_in;
        if (ale) begin
            adr_q <= ad_out[3:0];
        end
        if (rd_n && wr_n) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
        if (!wr_n && ad_oe) begin
            mem_q[adr_q] <= ad_out;
        end
    end
endmodule : lbc_mem_model

// *** tb/local_bus_cycle_signaling_tb.sv ***
// Self-checking bench for the local bus cycle controller.
// Assumes lbc_mem_model as the bus target; no other parties on the bus.
`timescale 1ns/10ps
module local_bus_cycle_signaling_tb
    import lbc_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid = 1'b0;
    logic [2:0]        req_type = 3'h7;
    logic [ADDR_W-1:0] req_addr = 20'h00000;
    logic [DATA_W-1:0] req_wdata = 8'h00;
    logic              req_lock = 1'b0;
    logic              req_rfsh = 1'b0;
    logic              at_boundary = 1'b0;
    logic [ADDR_W-1:0] ucs_base = 20'hf0000;
    logic [ADDR_W-1:0] ucs_limit = 20'hfffff;
    logic [ADDR_W-1:0] lcs_base = 20'h00000;
    logic [ADDR_W-1:0] lcs_limit = 20'h003ff;
    logic              ucs_en = 1'b1;
    logic              ucs_timed = 1'b1;
    logic              lcs_en = 1'b1;
    logic              lcs_timed = 1'b0;
    logic [WAIT_W-1:0] cs_waits = 4'h0;
    logic              hold = 1'b0;
    logic              once_n = 1'b1;
    logic [3:0]        wait_cfg = 4'h0;
    logic              ready, req_done, ad_oe, ale, rd_n, wr_n, ctl_oe;
    logic              lock_n, lock_n_oe, lock_pullup, once_pullup, rfsh_n;
    logic              ucs_n, lcs_n, hlda, resout;
    logic              cycle_type_bit0_l, cycle_type_bit1_l;
    logic              cycle_type_bit2_l;
    logic [DATA_W-1:0] rd_data, ad_in, ad_out;
    logic [HIGH_W-1:0] addr_hi;
    logic [2:0]        status, st;
    logic              saw_rd, saw_wr, saw_ucs, saw_lcs, saw_rfsh, saw_lock;
    logic              bad_grant = 1'b0;
    int                lat, num_errors = 0, checks = 0;

    assign status = {cycle_type_bit2_l, cycle_type_bit1_l, cycle_type_bit0_l};

    lbc_bus_ctrl i_lbc_bus_ctrl (
        .clk, .rst_n, .req_valid, .req_type, .req_addr, .req_wdata, .req_lock,
        .req_rfsh, .at_boundary, .req_done, .rd_data, .ucs_base, .ucs_limit,
        .ucs_en, .ucs_timed, .lcs_base, .lcs_limit, .lcs_en, .lcs_timed,
        .cs_waits, .ready, .hold, .once_n, .ad_in, .ad_out, .ad_oe, .addr_hi,
        .ale, .cycle_type_bit0_l, .cycle_type_bit1_l, .cycle_type_bit2_l,
        .rd_n, .wr_n, .ctl_oe, .lock_n, .lock_n_oe, .lock_pullup,
        .once_pullup, .rfsh_n, .ucs_n, .lcs_n, .hlda, .resout
    );

    lbc_mem_model i_lbc_mem_model (
        .clk, .ad_out, .ad_oe, .ale, .rd_n, .wr_n, .wait_cfg, .ad_in, .ready
    );

    // Free-running processor clock, 50 ns period.
    always #25 clk = ~clk;

    // A hold grant while lock is low is remembered for later judgement.
    always @(negedge clk) begin
        if (lock_n === 1'b0 && hlda === 1'b1) begin
            bad_grant = 1'b1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // One whole bus cycle; valid is held up to the edge at which req_done
    // is seen high and is dropped there by non-blocking assignment.
    task automatic bus_cycle(input logic [2:0] t, input logic [19:0] a,
                             input logic [7:0] d, input logic lk,
                             input logic rf);
        logic got_ale;
        {saw_rd, saw_wr, saw_ucs, saw_lcs, saw_rfsh, saw_lock} = 6'h00;
        got_ale = 1'b0;
        lat = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_type <= t;
        req_addr <= a;
        req_wdata <= d;
        req_lock <= lk;
        req_rfsh <= rf;
        for (int n = 0; n < 60 && req_done !== 1'b1; n++) begin
            @(negedge clk);
            if (ale === 1'b1) begin
                st = status;
                got_ale = 1'b1;
            end else if (got_ale) begin
                lat++;
            end
            saw_rd |= (rd_n === 1'b0);
            saw_wr |= (wr_n === 1'b0);
            saw_ucs |= (ucs_n === 1'b0);
            saw_lcs |= (lcs_n === 1'b0);
            saw_rfsh |= (rfsh_n === 1'b0);
            saw_lock |= (lock_n === 1'b0);
        end
        chk(req_done, 1);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask : bus_cycle

    task automatic apply_reset(input logic once);
        @(posedge clk);
        rst_n <= 1'b0;
        once_n <= once;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk(resout, 1);
        chk({status, rd_n, wr_n, lock_n, rfsh_n, ucs_n, lcs_n}, 9'h1ff);
        chk({ctl_oe, ad_oe, lock_n_oe, hlda, ale}, 5'h00);
        chk({lock_pullup, once_pullup}, 2'h3);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk(resout, 0);
        chk({lock_pullup, once_pullup}, 2'h0);
        chk(ctl_oe, once);
        if (!once) chk({lock_n_oe, ad_oe}, 0);
        @(posedge clk);
        once_n <= 1'b1;
    endtask : apply_reset

    task automatic t_types();
        logic [2:0] t;
        for (int i = 0; i < 7; i++) begin
            t = 3'(i);
            bus_cycle(t, 20'(i), 8'h5a, 1'b0, 1'b0);
            chk(st, t);
            chk(status, ST_NONE);
            chk(lat, 4);
            chk(saw_lcs, t inside {ST_FETCH, ST_MEMRD, ST_MEMWR});
            chk({saw_ucs, saw_rfsh}, 0);
            if (t == ST_IORD || t == ST_MEMRD) chk(saw_rd, 1);
            if (t == ST_IOWR || t == ST_MEMWR) chk({saw_wr, saw_rd}, 2);
        end
    endtask : t_types

    task automatic t_data();
        bus_cycle(ST_MEMWR, 20'h00009, 8'hc3, 1'b0, 1'b0);
        bus_cycle(ST_MEMRD, 20'h00009, 8'h00, 1'b0, 1'b0);
        chk(rd_data, 8'hc3);
        bus_cycle(ST_IOWR, 20'h0000a, 8'h3c, 1'b0, 1'b0);
        bus_cycle(ST_IORD, 20'h0000a, 8'h00, 1'b0, 1'b0);
        chk(rd_data, 8'h3c);
        @(posedge clk);
        wait_cfg <= 4'h3;
        bus_cycle(ST_MEMRD, 20'h00009, 8'h00, 1'b0, 1'b0);
        chk(lat >= 7, 1);
        chk(rd_data, 8'hc3);
    endtask : t_data

    task automatic t_selects();
        @(posedge clk);
        wait_cfg <= 4'hf;
        cs_waits <= 4'h2;
        bus_cycle(ST_MEMRD, 20'hf0005, 8'h00, 1'b0, 1'b0);
        chk(lat, 6);
        chk({saw_ucs, saw_lcs}, 2);
        chk(addr_hi, 12'hf00);
        lcs_timed <= 1'b1;
        bus_cycle(ST_MEMWR, 20'h00002, 8'h11, 1'b0, 1'b0);
        chk(lat, 6);
        chk({saw_ucs, saw_lcs}, 1);
        lcs_timed <= 1'b0;
        wait_cfg <= 4'h0;
        cs_waits <= 4'h0;
        ucs_en <= 1'b0;
        bus_cycle(ST_MEMRD, 20'hf0005, 8'h00, 1'b0, 1'b0);
        chk(saw_ucs, 0);
        ucs_en <= 1'b1;
        bus_cycle(ST_IORD, 20'hf0005, 8'h00, 1'b0, 1'b1);
        chk(saw_ucs, 0);
        bus_cycle(ST_MEMRD, 20'h00004, 8'h00, 1'b0, 1'b1);
        chk(saw_rfsh, 1);
        chk(rfsh_n, 1);
    endtask : t_selects

    task automatic t_hold_lock();
        at_boundary <= 1'b1;
        hold <= 1'b1;
        bus_cycle(ST_MEMRD, 20'h00001, 8'h00, 1'b1, 1'b0);
        chk(saw_lock, 1);
        bus_cycle(ST_MEMRD, 20'h00001, 8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 20 && hlda !== 1'b1; i++) @(negedge clk);
        chk({hlda, ctl_oe, bad_grant}, 3'h4);
        @(posedge clk);
        hold <= 1'b0;
        at_boundary <= 1'b0;
        for (int i = 0; i < 20 && hlda !== 1'b0; i++) @(negedge clk);
        chk(hlda, 0);
    endtask : t_hold_lock

    task automatic t_abort();
        @(posedge clk);
        wait_cfg <= 4'hf;
        req_valid <= 1'b1;
        req_type <= ST_MEMRD;
        req_addr <= 20'h00002;
        for (int i = 0; i < 20 && rd_n !== 1'b0; i++) @(negedge clk);
        @(posedge clk);
        rst_n <= 1'b0;
        req_valid <= 1'b0;
        wait_cfg <= 4'h0;
        @(negedge clk);
        chk({rd_n, status, resout}, 5'h1f);
        apply_reset(1'b0);
        apply_reset(1'b1);
    endtask : t_abort

    // Main sequence.
    initial begin
        apply_reset(1'b1);
        t_types();
        t_data();
        t_selects();
        t_hold_lock();
        t_abort();
        close_out();
    end

    // The whole run needs well under a thousand clocks; cut a hang short.
    initial begin
        #250000;
        num_errors++;
        close_out();
    end
endmodule : local_bus_cycle_signaling_tb
